// [rtl/nfi_pkg.sv]
// Purpose: Shared constants and types of the interrupt collection unit
// Assumes: Registers reached over a plain address/strobe port, 32-bit words
// Notes: Offsets are word indices; byte address is four times the index
package nfi_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] NFI_IDX_ENABLE = 8'h01;
  localparam logic [7:0] NFI_IDX_STATUS = 8'h02;
  localparam logic [7:0] NFI_IDX_ACK = 8'h03;
  localparam int NFI_ADDR_W = 10;
  localparam logic [1:0] NFI_ADDR_LSB = 2'h0;

  // ==========================================================================
  // Field layout
  localparam int NFI_NSRC = 20;
  localparam logic [19:0] NFI_EN_RW_MASK = 20'h1FFFF;
  localparam logic [19:0] NFI_EN_FIXED = 20'hE0000;
  localparam logic [19:0] NFI_EN_RESET = 20'h00000;
  localparam logic [19:0] NFI_STAT_RESET = 20'h00000;
  localparam logic [11:0] NFI_RSVD_RD = 12'h000;
  localparam logic [31:0] NFI_RD_IDLE = 32'h0000_0000;

  // Event bit positions
  localparam int NFI_B_RX_END = 0;
  localparam int NFI_B_TX_END = 1;
  localparam int NFI_B_IDLE = 2;
  localparam int NFI_B_EXT_MOD = 3;
  localparam int NFI_B_CARD_ACT = 4;
  localparam int NFI_B_STATE_CHG = 5;
  localparam int NFI_B_EXT_OFF = 6;
  localparam int NFI_B_EXT_ON = 7;
  localparam int NFI_B_OWN_OFF = 8;
  localparam int NFI_B_OWN_ON = 9;
  localparam int NFI_B_FIELD_ERR = 10;
  localparam int NFI_B_TIMER0 = 11;
  localparam int NFI_B_TIMER1 = 12;
  localparam int NFI_B_TIMER2 = 13;
  localparam int NFI_B_SOF = 14;
  localparam int NFI_B_SUBCARRIER = 15;
  localparam int NFI_B_OVERTEMP = 16;
  localparam int NFI_B_GEN_ERR = 17;
  localparam int NFI_B_NVM_FAULT = 18;
  localparam int NFI_B_LPCD = 19;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic low_power_card_detect_flag;
    logic nvm_program_fault_flag;
    logic general_error_flag;
    logic overtemp_flag;
    logic subcarrier_seen_flag;
    logic frame_start_seen_flag;
    logic timer_two_flag;
    logic timer_one_flag;
    logic timer_zero_flag;
    logic field_activity_error_flag;
    logic own_field_on_flag;
    logic own_field_off_flag;
    logic ext_field_on_flag;
    logic ext_field_off_flag;
    logic transceive_state_flag;
    logic card_activation_flag;
    logic ext_modulation_flag;
    logic idle_flag;
    logic tx_end_flag;
    logic rx_end_flag;
  } nfi_events_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [NFI_ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } nfi_bus_req_t;

  typedef struct packed {
    logic [16:0] pin_gate;
    logic [19:0] flags;
    logic irq;
    logic [31:0] rdata;
  } nfi_state_t;

endpackage : nfi_pkg

// [rtl/nfi_irq_unit.sv]
// Purpose: Interrupt collection unit: sticky event flags, pin gates, ack register
// Assumes: Event inputs are one-cycle or level pulses synchronous to core_clk
// Notes: Set wins over a same-cycle acknowledge; irq output is registered
// Summary of operation
// [RL1] Gates 19..17 are fixed one, unwritable, so those events always reach the pin
// [RL2] Gates 16..0 are read/write, reset zero, each passes its flag to the pin
// [RL3] Timer two, one, zero gates sit at bits 13, 12, 11
// [RL4] Status bits match gate positions, are read-only and reset to zero
// [RL5] Bits 0..5: rx end, tx end, idle, modulation, card activation, state change
// [RL6] Bits 6..10: ext field off, ext on, own off, own on, field error
// [RL7] Bits 11..13 timers, 14 frame start, 15 subcarrier, 16 overtemp
// [RL8] Bits 17 general error, 18 nvm fault, 19 card detect; 31..20 reserved
// [RL9] Writing one to an ack bit clears the matching flag; bits 19..0 writable
// [RL10] Ack bit 5 clears state change, bit 4 clears card activation
// [RL11] Pin high while any flag and gate set; zero acks do nothing; flags sticky
// [RL12] Host reads status on interrupt, then acks handled events before waiting
//
// The address-and-strobe port was chosen for this implementation.
module nfi_irq_unit
  import nfi_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Register port
  input wire logic [NFI_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Event sources
  input wire nfi_events_t events,
  // Interrupt request pin
  output logic irq_out
);

  // ==========================================================================
  // State
  nfi_state_t s_q;
  nfi_state_t s_d;
  nfi_bus_req_t req;
  logic [19:0] ev_vec;
  logic [19:0] gate_full;
  logic [19:0] ack_vec;
  logic [19:0] flags_next;
  logic sel_en;
  logic sel_stat;
  logic sel_ack;

  // Bus request bundle
  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
  assign ev_vec = events;

  // Address decode on word index
  assign sel_en = (req.addr == {NFI_IDX_ENABLE, NFI_ADDR_LSB});
  assign sel_stat = (req.addr == {NFI_IDX_STATUS, NFI_ADDR_LSB});
  assign sel_ack = (req.addr == {NFI_IDX_ACK, NFI_ADDR_LSB});

  // Full gate vector: fixed upper gates plus writable ones
  assign gate_full = NFI_EN_FIXED | {3'h0, s_q.pin_gate}; // [RL1] [RL2] [RL3]

  // Acknowledge vector from a write of ones
  assign ack_vec = (req.wr && sel_ack) ? req.wdata[19:0] : 20'h00000; // [RL9] [RL10]

  // Per-bit sticky flag update, set wins over acknowledge
  genvar gi;
  generate
    for (gi = 0; gi < NFI_NSRC; gi++)
    begin : g_flag
      assign flags_next[gi] = ev_vec[gi] | (s_q.flags[gi] & ~ack_vec[gi]); // [RL11] [RL9]
      // Per-bit flag checks
      bit_set_a: assert property ( // [RL4]
        @(posedge core_clk) disable iff (rst)
        (clk_en && ev_vec[gi]) |=> s_q.flags[gi])
        else $error("event did not set its flag");
      bit_sticky_a: assert property ( // [RL11]
        @(posedge core_clk) disable iff (rst)
        (clk_en && s_q.flags[gi] && !ack_vec[gi]) |=> s_q.flags[gi])
        else $error("flag dropped without its ack");
      bit_ack_a: assert property ( // [RL9]
        @(posedge core_clk) disable iff (rst)
        (clk_en && ack_vec[gi] && !ev_vec[gi]) |=> !s_q.flags[gi])
        else $error("ack did not clear its flag");
      bit_quiet_a: assert property ( // [RL4]
        @(posedge core_clk) disable iff (rst)
        (clk_en && !ev_vec[gi] && !s_q.flags[gi]) |=> !s_q.flags[gi])
        else $error("flag set with no event");
    end
  endgenerate

  // Next-state logic
  always_comb
  begin
    s_d = s_q;
    s_d.flags = flags_next; // [RL4] [RL5] [RL6] [RL7] [RL8]
    if (req.wr && sel_en)
    begin
      s_d.pin_gate = req.wdata[16:0] & NFI_EN_RW_MASK[16:0]; // [RL2]
    end
    s_d.irq = |(flags_next & (NFI_EN_FIXED |
               {3'h0, s_d.pin_gate})); // [RL11]
    s_d.rdata = NFI_RD_IDLE;
    if (req.rd)
    begin
      if (sel_en)
      begin
        s_d.rdata = {NFI_RSVD_RD, gate_full}; // [RL1]
      end
      else if (sel_stat)
      begin
        s_d.rdata = {NFI_RSVD_RD, s_q.flags}; // [RL4] [RL8]
      end
      else
      begin
        s_d.rdata = NFI_RD_IDLE; // Ack and unmapped read zero
      end
    end
  end

  // State register with clock enable
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q.pin_gate <= NFI_EN_RESET[16:0];
      s_q.flags <= NFI_STAT_RESET;
      s_q.irq <= 1'b0;
      s_q.rdata <= NFI_RD_IDLE;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = s_q.rdata;
  assign irq_out = s_q.irq;

  // ==========================================================================
  // Assertions
  property p_sticky;
    @(posedge core_clk) disable iff (rst)
    (clk_en && s_q.flags[NFI_B_TIMER0] && !ack_vec[NFI_B_TIMER0])
      |=> s_q.flags[NFI_B_TIMER0];
  endproperty

  flag_sticky_a: assert property (p_sticky) // [RL11]
    else $error("flag dropped without ack");

  ack_clears_a: assert property ( // [RL9]
    @(posedge core_clk) disable iff (rst)
    (clk_en && ack_vec[NFI_B_CARD_ACT] && !ev_vec[NFI_B_CARD_ACT])
      |=> !s_q.flags[NFI_B_CARD_ACT])
    else $error("ack did not clear flag");

  set_wins_a: assert property ( // [RL9]
    @(posedge core_clk) disable iff (rst)
    (clk_en && ev_vec[NFI_B_STATE_CHG]) |=> s_q.flags[NFI_B_STATE_CHG])
    else $error("event lost");

  fixed_gate_a: assert property ( // [RL1]
    @(posedge core_clk) disable iff (rst)
    (clk_en && ev_vec[NFI_B_LPCD]) |=> irq_out)
    else $error("fixed gate event missed pin");

  gate_blocks_a: assert property ( // [RL2]
    @(posedge core_clk) disable iff (rst)
    (s_q.flags[16:0] & s_q.pin_gate) == 17'h0 && s_q.flags[19:17] == 3'h0
      |-> !irq_out)
    else $error("pin high with no gated flag");

  enable_read_a: assert property ( // [RL1]
    @(posedge core_clk) disable iff (rst)
    (clk_en && req.rd && sel_en) |=> reg_rdata[19:17] == 3'h7
      && reg_rdata[31:20] == 12'h000)
    else $error("enable readback wrong");

  status_read_a: assert property ( // [RL4]
    @(posedge core_clk) disable iff (rst)
    (clk_en && req.rd && sel_stat) |=> reg_rdata[19:0] == $past(s_q.flags))
    else $error("status readback wrong");

  timer_gate_a: assert property ( // [RL3]
    @(posedge core_clk) disable iff (rst)
    (clk_en && req.wr && sel_en) |=> s_q.pin_gate[13:11] == $past(req.wdata[13:11]))
    else $error("timer gate not written");

  zero_ack_a: assert property ( // [RL11]
    @(posedge core_clk) disable iff (rst)
    (clk_en && req.wr && sel_ack && req.wdata[NFI_B_GEN_ERR] == 1'b0
      && s_q.flags[NFI_B_GEN_ERR]) |=> s_q.flags[NFI_B_GEN_ERR])
    else $error("zero ack cleared flag");

  // Register and pin checks
  state_ack_a: assert property ( // [RL10]
    @(posedge core_clk) disable iff (rst)
    (clk_en && ack_vec[NFI_B_STATE_CHG] && !ev_vec[NFI_B_STATE_CHG])
      |=> !s_q.flags[NFI_B_STATE_CHG])
    else $error("state change ack did not clear flag");

  fixed_any_a: assert property ( // [RL1]
    @(posedge core_clk) disable iff (rst)
    (clk_en && ev_vec[NFI_B_LPCD:NFI_B_GEN_ERR] != 3'h0) |=> irq_out)
    else $error("always-on event missed pin");

  irq_level_a: assert property ( // [RL11]
    @(posedge core_clk) disable iff (rst)
    ((s_q.flags & gate_full) != 20'h00000) |-> irq_out)
    else $error("gated flag but pin low");

  gate_write_a: assert property ( // [RL2]
    @(posedge core_clk) disable iff (rst)
    (clk_en && req.wr && sel_en) |=> s_q.pin_gate == $past(req.wdata[16:0]))
    else $error("gate write lost");

  gate_hold_a: assert property ( // [RL2]
    @(posedge core_clk) disable iff (rst)
    (clk_en && !(req.wr && sel_en))
      |=> s_q.pin_gate == $past(s_q.pin_gate))
    else $error("gate changed without write");

  status_ro_a: assert property ( // [RL4]
    @(posedge core_clk) disable iff (rst)
    (clk_en && req.wr && sel_stat && ev_vec == 20'h00000)
      |=> s_q.flags == $past(s_q.flags))
    else $error("status write changed flags");

  ack_read_a: assert property ( // [RL9]
    @(posedge core_clk) disable iff (rst)
    (clk_en && req.rd && sel_ack) |=> reg_rdata == NFI_RD_IDLE)
    else $error("ack register read not zero");

  rdata_idle_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && !req.rd) |=> reg_rdata == NFI_RD_IDLE)
    else $error("read data held past its cycle");

  rsvd_read_a: assert property ( // [RL8]
    @(posedge core_clk) disable iff (rst) reg_rdata[31:NFI_NSRC] == NFI_RSVD_RD)
    else $error("reserved bits read nonzero");

  state_freeze_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !clk_en |=> s_q == $past(s_q))
    else $error("state moved while clock enable low");

  // Event inputs land at their status positions
  rx_end_map_a: assert property ( // [RL5]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.rx_end_flag) |=> s_q.flags[NFI_B_RX_END])
    else $error("rx end flag misplaced");

  tx_end_map_a: assert property ( // [RL5]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.tx_end_flag) |=> s_q.flags[NFI_B_TX_END])
    else $error("tx end flag misplaced");

  idle_map_a: assert property ( // [RL5]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.idle_flag) |=> s_q.flags[NFI_B_IDLE])
    else $error("idle flag misplaced");

  ext_mod_map_a: assert property ( // [RL5]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.ext_modulation_flag) |=> s_q.flags[NFI_B_EXT_MOD])
    else $error("modulation flag misplaced");

  card_act_map_a: assert property ( // [RL5]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.card_activation_flag) |=> s_q.flags[NFI_B_CARD_ACT])
    else $error("card activation flag misplaced");

  state_chg_map_a: assert property ( // [RL5]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.transceive_state_flag) |=> s_q.flags[NFI_B_STATE_CHG])
    else $error("state change flag misplaced");

  ext_off_map_a: assert property ( // [RL6]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.ext_field_off_flag) |=> s_q.flags[NFI_B_EXT_OFF])
    else $error("ext field off flag misplaced");

  ext_on_map_a: assert property ( // [RL6]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.ext_field_on_flag) |=> s_q.flags[NFI_B_EXT_ON])
    else $error("ext field on flag misplaced");

  own_off_map_a: assert property ( // [RL6]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.own_field_off_flag) |=> s_q.flags[NFI_B_OWN_OFF])
    else $error("own field off flag misplaced");

  own_on_map_a: assert property ( // [RL6]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.own_field_on_flag) |=> s_q.flags[NFI_B_OWN_ON])
    else $error("own field on flag misplaced");

  field_err_map_a: assert property ( // [RL6]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.field_activity_error_flag) |=> s_q.flags[NFI_B_FIELD_ERR])
    else $error("field error flag misplaced");

  timer0_map_a: assert property ( // [RL7]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.timer_zero_flag) |=> s_q.flags[NFI_B_TIMER0])
    else $error("timer zero flag misplaced");

  timer1_map_a: assert property ( // [RL7]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.timer_one_flag) |=> s_q.flags[NFI_B_TIMER1])
    else $error("timer one flag misplaced");

  timer2_map_a: assert property ( // [RL7]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.timer_two_flag) |=> s_q.flags[NFI_B_TIMER2])
    else $error("timer two flag misplaced");

  frame_start_map_a: assert property ( // [RL7]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.frame_start_seen_flag) |=> s_q.flags[NFI_B_SOF])
    else $error("frame start flag misplaced");

  subcarrier_map_a: assert property ( // [RL7]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.subcarrier_seen_flag) |=> s_q.flags[NFI_B_SUBCARRIER])
    else $error("subcarrier flag misplaced");

  overtemp_map_a: assert property ( // [RL7]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.overtemp_flag) |=> s_q.flags[NFI_B_OVERTEMP])
    else $error("overtemp flag misplaced");

  gen_err_map_a: assert property ( // [RL8]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.general_error_flag) |=> s_q.flags[NFI_B_GEN_ERR])
    else $error("general error flag misplaced");

  nvm_fault_map_a: assert property ( // [RL8]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.nvm_program_fault_flag) |=> s_q.flags[NFI_B_NVM_FAULT])
    else $error("nvm fault flag misplaced");

  card_detect_map_a: assert property ( // [RL8]
    @(posedge core_clk) disable iff (rst)
    (clk_en && events.low_power_card_detect_flag) |=> s_q.flags[NFI_B_LPCD])
    else $error("card detect flag misplaced");

  irq_seen_c: cover property (@(posedge core_clk) disable iff (rst) $rose(irq_out));
  ack_seen_c: cover property (@(posedge core_clk) disable iff (rst) $fell(irq_out));
  both_c: cover property (@(posedge core_clk) disable iff (rst)
    ev_vec[NFI_B_TIMER2] && ack_vec[NFI_B_TIMER2]);
  freeze_c: cover property (@(posedge core_clk) disable iff (rst)
    !clk_en && ev_vec != 20'h00000);
  misalign_c: cover property (@(posedge core_clk) disable iff (rst)
    req.wr && req.addr[1:0] != NFI_ADDR_LSB);

endmodule : nfi_irq_unit

// [tb/nfi_host_model.sv]
// Purpose: Host side that watches the interrupt request pin
// Assumes: Pin is an active high level, synchronous to core_clk
// Notes: Counts fresh assertions so the bench can match them
module nfi_host_model
  import nfi_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Interrupt pin and assertion count
  input wire logic irq_out,
  output int n_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irq_seen_q;
  // One service round per rising pin, the bench reads then acks
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_seen_q <= 1'b0;
      n_irq <= 0;
    end
    else
    begin
      irq_seen_q <= irq_out;
      if (irq_out && !irq_seen_q)
        n_irq <= n_irq + 1;
    end
  end
endmodule : nfi_host_model

// [tb/tb_top.sv]
// Purpose: Self-checking bench of the interrupt collection unit
// Assumes: One read or write per task, strobes one cycle long
// Notes: Every source is walked through set, gate, zero ack and ack
module tb_top
  import nfi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [NFI_ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  nfi_events_t events = '0;
  logic irq_out;
  int n_irq;
  int n_mismatch = 0;
  int total_checks = 0;
  nfi_irq_unit u_dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .events(events), .irq_out(irq_out));
  nfi_host_model u_host (.core_clk(core_clk), .rst(rst), .irq_out(irq_out), .n_irq(n_irq));
  // Clock of 4 ns
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus_wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : bus_wr
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd_chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // ==========================================================================
  // Scenarios
  task automatic reg_access();
    rd_chk(10'h004, 32'h000E_0000);
    rd_chk(10'h008, 32'h0000_0000);
    rd_chk(10'h00C, 32'h0000_0000);
    bus_wr(10'h004, 32'hFFFF_FFFF);
    rd_chk(10'h004, 32'h000F_FFFF);
    bus_wr(10'h004, 32'h0000_0000);
    bus_wr(10'h008, 32'hFFFF_FFFF);
    bus_wr(10'h3FC, 32'hFFFF_FFFF);
    rd_chk(10'h008, 32'h0000_0000);
    rd_chk(10'h3FC, 32'h0000_0000);
    bus_wr(10'h005, 32'hFFFF_FFFF);
    rd_chk(10'h005, 32'h0000_0000);
    rd_chk(10'h004, 32'h000E_0000);
  endtask : reg_access
  // Reset in mid-run drops a pending gated flag and all writable gates
  task automatic reset_mid();
    bus_wr(10'h004, 32'h0000_0001);
    @(posedge core_clk);
    events <= nfi_events_t'(20'h00001);
    @(posedge core_clk);
    events <= '0;
    @(posedge core_clk);
    #1 chk({31'h0, irq_out}, 32'h1);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk({31'h0, irq_out}, 32'h0);
    rd_chk(10'h004, 32'h000E_0000);
    rd_chk(10'h008, 32'h0000_0000);
  endtask : reset_mid
  // Event and ack of one bit in the same cycle: the event wins
  task automatic set_wins();
    @(posedge core_clk);
    events <= nfi_events_t'(20'h02000);
    reg_wr <= 1'b1;
    reg_addr <= 10'h00C;
    reg_wdata <= 32'h0000_2000;
    @(posedge core_clk);
    events <= '0;
    reg_wr <= 1'b0;
    rd_chk(10'h008, 32'h0000_2000);
    bus_wr(10'h00C, 32'h0000_2000);
    rd_chk(10'h008, 32'h0000_0000);
  endtask : set_wins
  // Clock enable low: event and gate write are both ignored
  task automatic freeze_hold();
    @(posedge core_clk);
    clk_en <= 1'b0;
    events <= nfi_events_t'(20'h80000);
    reg_wr <= 1'b1;
    reg_addr <= 10'h004;
    reg_wdata <= 32'h0001_FFFF;
    @(posedge core_clk);
    clk_en <= 1'b1;
    events <= '0;
    reg_wr <= 1'b0;
    @(posedge core_clk);
    #1 chk({31'h0, irq_out}, 32'h0);
    rd_chk(10'h004, 32'h000E_0000);
    rd_chk(10'h008, 32'h0000_0000);
  endtask : freeze_hold
  task automatic each_source();
    logic [31:0] m;
    for (int i = 0; i < 20; i++)
    begin
      m = 32'h1 << i;
      @(posedge core_clk);
      events <= nfi_events_t'(m[19:0]);
      @(posedge core_clk);
      events <= '0;
      @(posedge core_clk);
      #1 chk({31'h0, irq_out}, {31'h0, i > 16});
      rd_chk(10'h008, m);
      bus_wr(10'h004, m);
      @(posedge core_clk);
      #1 chk({31'h0, irq_out}, 32'h1);
      bus_wr(10'h00C, ~m);
      rd_chk(10'h008, m);
      bus_wr(10'h00C, m);
      rd_chk(10'h008, 32'h0);
      #1 chk({31'h0, irq_out}, 32'h0);
      bus_wr(10'h004, 32'h0);
    end
  endtask : each_source
  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    reg_access();
    reset_mid();
    set_wins();
    freeze_hold();
    each_source();
    chk(32'(n_irq), 32'd20);
    give_verdict();
  end
  initial
  begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
endmodule : tb_top
